// file: core/serial_io_uart_channel.sv
// one channel of the serial i/o unit: uart mode and clock-synchronous options
// assumes a cpu-side register port on clk and async pins synchronised here
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ns
module serial_io_uart_channel
  import serial_io_uart_pkg::*;
#(
  parameter int CHANNEL = 0
) (
  input  logic        clk,
  input  logic        resetn,
  input  logic        ce,
  input  logic [2:0]  addr,
  input  logic [15:0] wdata,
  input  logic        wr,
  input  logic        rd,
  output logic [15:0] rdata,
  input  logic        serial_data_in,
  output logic        serial_data_out,
  output logic        serial_data_out_oe_n,
  input  logic        transfer_clock_pin_in,
  output logic        transfer_clock_pin_out,
  output logic        transfer_clock_pin_oe_n,
  output logic        second_clock_output_pin,
  output logic        second_clock_output_pin_oe_n,
  input  logic        flow_pin_in,
  output logic        flow_pin_out,
  output logic        flow_pin_oe_n,
  input  logic        flow_sep_cts_in,
  output logic        flow_sep_rts_out,
  output logic        flow_sep_rts_oe_n,
  output logic        tx_irq,
  output logic        rx_irq
);

  localparam logic IS_CH0 = (CHANNEL == 0);
  localparam logic IS_CH1 = (CHANNEL == 1);
  localparam logic IS_CH2 = (CHANNEL == 2);

  function automatic logic [3:0] bit_pos(input logic [3:0] idx, input logic [3:0] len,
                                         input logic msb);
    bit_pos = msb ? 4'(len - 4'h1 - idx) : idx;
  endfunction

  function automatic logic [8:0] char_mask(input logic [3:0] len);
    char_mask = 9'((10'h001 << len) - 10'h001);
  endfunction

  function automatic logic par_bit(input logic [8:0] d, input logic [3:0] len,
                                   input logic odd);
    par_bit = (^(d & char_mask(len))) ^ odd;
  endfunction

  logic         rst_meta_q;
  logic         rst_n_q;
  logic [3:0]   sync1_q;
  logic [3:0]   sync2_q;
  logic         clk_prev_q;
  logic [7:0]   mode_q;
  logic [7:0]   ctrl0_q;
  logic [7:0]   ctrl1_q;
  logic [7:0]   aux_q;
  logic [7:0]   brg_q;
  logic [7:0]   brg_cnt_q;
  logic [4:0]   pre_q;
  logic [8:0]   txbuf_q;
  logic         tx_full_q;
  logic [8:0]   rxbuf_q;
  logic         rx_full_q;
  logic         ovr_q;
  logic         frm_q;
  logic         per_q;
  logic         cont_go_q;
  logic         sclk_q;
  tx_state_type tx_state_q;
  logic [3:0]   tx_os_q;
  logic [3:0]   tx_idx_q;
  logic [8:0]   tx_shift_q;
  logic         tx_stop2_q;
  logic         txd_q;
  rx_state_type rx_state_q;
  logic [3:0]   rx_os_q;
  logic [3:0]   rx_idx_q;
  logic [8:0]   rx_shift_q;
  logic         rx_fe_q;
  logic         rx_pe_q;
  logic         rx_stop2_q;
  logic         rx_done_q;
  logic         tx_irq_q;
  logic         rx_irq_q;
  logic [15:0]  rdata_q;

  // decoded configuration
  logic [2:0] mode;
  logic       sync_mode;
  logic       uart_mode;
  logic       active;
  logic [3:0] char_len;
  logic       ext_clk;
  logic       multi_sel;
  logic       multi_pin;
  logic       sep_on;
  logic       flow_off;
  logic       rts_sel;
  logic       cts_ok;
  logic       inv_data;
  logic       inv_pin;
  logic       msb_first;
  logic       idle_lvl;
  logic       rxd;
  logic       ext_lvl;
  logic       sleep_on;

  assign mode      = mode_q[2:0];
  assign sync_mode = (mode == MODE_SYNC);
  assign uart_mode = (mode == MODE_U7) || (mode == MODE_U8) || (mode == MODE_U9);
  assign active    = sync_mode || uart_mode;
  assign char_len  = (mode == MODE_U7) ? LEN7 : (mode == MODE_U9) ? LEN9 : LEN8;
  assign ext_clk   = mode_q[MODE_EXT] && !IS_CH2;
  assign multi_sel = (aux_q[AUX_CLKSEL +: 2] != 2'h0);
  assign multi_pin = IS_CH1 && multi_sel && !ext_clk;
  assign sep_on    = IS_CH0 && aux_q[AUX_SEP] && !multi_sel;
  assign flow_off  = ctrl0_q[C0_FLOW_OFF] || multi_pin;
  assign rts_sel   = ctrl0_q[C0_RTS];
  assign inv_data  = IS_CH2 && ctrl1_q[C1_INVDATA];
  assign inv_pin   = IS_CH2 && ctrl1_q[C1_INVPIN];
  assign msb_first = ctrl0_q[C0_MSB];
  assign idle_lvl  = !ctrl0_q[C0_CPOL];
  assign rxd       = sync2_q[0] ^ inv_pin;
  assign ext_lvl   = sync2_q[1];
  assign sleep_on  = (IS_CH0 || IS_CH1) && mode_q[MODE_SLEEP] && uart_mode;

  // cts is active low; sampled from the separate pin when that is routed
  logic cts_lvl;
  assign cts_lvl = sep_on ? sync2_q[3] : sync2_q[2];
  assign cts_ok  = flow_off || rts_sel || !cts_lvl;

  logic wr_txbuf;
  logic wr_ctrl1;
  logic rd_rx;
  assign wr_txbuf = wr && (addr == ADDR_TXBUF);
  assign wr_ctrl1 = wr && (addr == ADDR_CTRL1);
  assign rd_rx    = rd && (addr == ADDR_RXBUF);

  // reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // pin synchronisers; only the second stage is read
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sync1_q    <= 4'hf;
      sync2_q    <= 4'hf;
      clk_prev_q <= 1'b1;
    end else if (ce) begin
      sync1_q    <= {flow_sep_cts_in, flow_pin_in, transfer_clock_pin_in, serial_data_in};
      sync2_q    <= sync1_q;
      clk_prev_q <= sync2_q[1];
    end
  end

  // bit-rate generator
  logic src_tick;
  logic base_tick;
  logic brg_tick;
  always_comb begin
    unique case (ctrl0_q[C0_CLKSRC +: 2])
      2'h0:    src_tick = 1'b1;
      2'h1:    src_tick = (pre_q[2:0] == DIV8_LAST);
      default: src_tick = (pre_q == DIV32_LAST);
    endcase
  end
  assign base_tick = ext_clk ? (ext_lvl && !clk_prev_q) : src_tick;
  assign brg_tick  = base_tick && (brg_cnt_q == 8'h00);

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pre_q     <= 5'h00;
      brg_cnt_q <= 8'h00;
    end else if (ce) begin
      pre_q <= pre_q + 5'h01;
      if (base_tick) begin
        brg_cnt_q <= (brg_cnt_q == 8'h00) ? brg_q : brg_cnt_q - 8'h01;
      end
    end
  end

  // sync-mode clock and its edges; internal clock toggles once per divider tick
  logic sync_busy;
  logic lead_edge;
  logic trail_edge;
  assign sync_busy  = (tx_state_q == TX_SYNC);
  assign lead_edge  = sync_busy && (ext_clk ? (clk_prev_q == idle_lvl && ext_lvl != idle_lvl)
                                            : (brg_tick && sclk_q == idle_lvl));
  assign trail_edge = sync_busy && (ext_clk ? (clk_prev_q != idle_lvl && ext_lvl == idle_lvl)
                                            : (brg_tick && sclk_q != idle_lvl));

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sclk_q <= 1'b1;
    end else if (ce) begin
      if (!sync_busy) sclk_q <= idle_lvl;
      else if (brg_tick) sclk_q <= !sclk_q;
    end
  end

  // register writes
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_q  <= REG_RST;
      ctrl0_q <= REG_RST;
      ctrl1_q <= REG_RST;
      aux_q   <= REG_RST;
      brg_q   <= REG_RST;
    end else if (ce && wr) begin
      unique case (addr)
        ADDR_MODE:  mode_q  <= wdata[7:0];
        ADDR_CTRL0: ctrl0_q <= wdata[7:0];
        ADDR_CTRL1: ctrl1_q <= wdata[7:0];
        ADDR_AUX:   aux_q   <= wdata[7:0];
        ADDR_BRG:   brg_q   <= wdata[7:0];
        default:    ;
      endcase
    end
  end

  // transmitter
  logic tx_go;
  logic tx_load;
  logic tx_bit_end;
  logic tx_stop_more;
  logic tx_done;
  assign tx_go        = ctrl1_q[C1_TXEN] && tx_full_q && cts_ok;
  assign tx_load      = (tx_state_q == TX_IDLE) && active && tx_go;
  assign tx_bit_end   = brg_tick && (tx_os_q == OS_LAST);
  assign tx_stop_more = mode_q[MODE_STOP2] && !tx_stop2_q;
  assign tx_done      = ((tx_state_q == TX_STOP) && tx_bit_end && !tx_stop_more)
                     || (trail_edge && tx_idx_q == SYNC_LAST);

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_state_q <= TX_IDLE;
      tx_os_q    <= 4'h0;
      tx_idx_q   <= 4'h0;
      tx_shift_q <= TXBUF_RST;
      tx_stop2_q <= 1'b0;
      txd_q      <= 1'b1;
    end else if (ce) begin
      if (brg_tick) tx_os_q <= tx_os_q + 4'h1;
      unique case (tx_state_q)
        TX_IDLE: begin
          txd_q    <= 1'b1;
          tx_os_q  <= 4'h0;
          tx_idx_q <= 4'h0;
          if (uart_mode && tx_go) begin
            tx_shift_q <= txbuf_q;
            txd_q      <= 1'b0;
            tx_state_q <= TX_START;
          end else if (sync_mode && (tx_go || cont_go_q)) begin
            tx_shift_q <= tx_go ? txbuf_q : 9'h1ff;
            tx_state_q <= TX_SYNC;
          end
        end
        TX_START: if (tx_bit_end) begin
          tx_state_q <= TX_DATA;
          txd_q      <= tx_shift_q[bit_pos(4'h0, char_len, msb_first)];
        end
        TX_DATA: if (tx_bit_end) begin
          if (tx_idx_q == char_len - 4'h1) begin
            tx_stop2_q <= 1'b0;
            if (mode_q[MODE_PAR]) begin
              tx_state_q <= TX_PAR;
              txd_q      <= par_bit(tx_shift_q, char_len, mode_q[MODE_ODD]);
            end else begin
              tx_state_q <= TX_STOP;
              txd_q      <= 1'b1;
            end
          end else begin
            tx_idx_q <= tx_idx_q + 4'h1;
            txd_q    <= tx_shift_q[bit_pos(tx_idx_q + 4'h1, char_len, msb_first)];
          end
        end
        TX_PAR: if (tx_bit_end) begin
          tx_state_q <= TX_STOP;
          txd_q      <= 1'b1;
        end
        TX_STOP: if (tx_bit_end) begin
          if (tx_stop_more) tx_stop2_q <= 1'b1;
          else tx_state_q <= TX_IDLE;
        end
        TX_SYNC: begin
          if (lead_edge) txd_q <= tx_shift_q[bit_pos(tx_idx_q, LEN8, msb_first)];
          if (trail_edge) begin
            if (tx_idx_q == SYNC_LAST) tx_state_q <= TX_IDLE;
            else tx_idx_q <= tx_idx_q + 4'h1;
          end
        end
      endcase
      if (!active) tx_state_q <= TX_IDLE;
    end
  end

  // transmit buffer, request and continuous-receive restart
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      txbuf_q   <= TXBUF_RST;
      tx_full_q <= 1'b0;
      tx_irq_q  <= 1'b0;
      cont_go_q <= 1'b0;
    end else if (ce) begin
      tx_irq_q <= 1'b0;
      if (tx_load) begin
        tx_full_q <= 1'b0;
        if (!ctrl1_q[C1_TXCAUSE]) tx_irq_q <= 1'b1;
      end
      if (tx_done && ctrl1_q[C1_TXCAUSE]) tx_irq_q <= 1'b1;
      if (wr_txbuf) begin
        txbuf_q   <= inv_data ? ~wdata[8:0] : wdata[8:0];
        tx_full_q <= 1'b1;
      end
      if (tx_state_q == TX_IDLE && sync_mode) cont_go_q <= 1'b0;
      if (rd_rx && sync_mode && ctrl1_q[C1_CONTRX] && ctrl1_q[C1_RXEN]) cont_go_q <= 1'b1;
    end
  end

  // receiver
  logic rx_mid;
  logic rx_en;
  assign rx_mid = brg_tick && (rx_os_q == OS_LAST);
  assign rx_en  = ctrl1_q[C1_RXEN];

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_state_q <= RX_IDLE;
      rx_os_q    <= 4'h0;
      rx_idx_q   <= 4'h0;
      rx_shift_q <= 9'h000;
      rx_fe_q    <= 1'b0;
      rx_pe_q    <= 1'b0;
      rx_stop2_q <= 1'b0;
      rx_done_q  <= 1'b0;
    end else if (ce) begin
      rx_done_q <= 1'b0;
      if (brg_tick) rx_os_q <= rx_os_q + 4'h1;
      unique case (rx_state_q)
        RX_IDLE: begin
          rx_os_q    <= 4'h0;
          rx_idx_q   <= 4'h0;
          rx_stop2_q <= 1'b0;
          if (uart_mode && rx_en && !rxd) begin
            rx_shift_q <= 9'h000;
            rx_fe_q    <= 1'b0;
            rx_pe_q    <= 1'b0;
            rx_state_q <= RX_START;
          end
          if (trail_edge && rx_en) begin
            rx_shift_q[bit_pos(tx_idx_q, LEN8, msb_first)] <= rxd;
            rx_fe_q <= 1'b0;
            rx_pe_q <= 1'b0;
            if (tx_idx_q == SYNC_LAST) rx_done_q <= 1'b1;
          end
        end
        // a start bit must still be low at mid-bit, else it was a glitch
        RX_START: if (brg_tick && rx_os_q == OS_HALF) begin
          rx_os_q    <= 4'h0;
          rx_state_q <= rxd ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_mid) begin
          rx_shift_q[bit_pos(rx_idx_q, char_len, msb_first)] <= rxd;
          if (rx_idx_q == char_len - 4'h1) begin
            rx_state_q <= mode_q[MODE_PAR] ? RX_PAR : RX_STOP;
          end else begin
            rx_idx_q <= rx_idx_q + 4'h1;
          end
        end
        RX_PAR: if (rx_mid) begin
          rx_pe_q    <= (rxd != par_bit(rx_shift_q, char_len, mode_q[MODE_ODD]));
          rx_state_q <= RX_STOP;
        end
        RX_STOP: if (rx_mid) begin
          if (!rxd) rx_fe_q <= 1'b1;
          if (mode_q[MODE_STOP2] && !rx_stop2_q) begin
            rx_stop2_q <= 1'b1;
          end else begin
            rx_state_q <= RX_IDLE;
            rx_done_q  <= 1'b1;
          end
        end
      endcase
      if (!rx_en || !uart_mode) rx_state_q <= RX_IDLE;
    end
  end

  // receive buffer and error flags
  logic [8:0] rx_word;
  logic       rx_accept;
  assign rx_word   = rx_shift_q & char_mask(char_len);
  assign rx_accept = !(sleep_on && !rx_word[char_len - 4'h1]);

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rxbuf_q   <= 9'h000;
      rx_full_q <= 1'b0;
      ovr_q     <= 1'b0;
      frm_q     <= 1'b0;
      per_q     <= 1'b0;
      rx_irq_q  <= 1'b0;
    end else if (ce) begin
      rx_irq_q <= 1'b0;
      if (rd_rx) rx_full_q <= 1'b0;
      // clear first so a same-cycle error still lands
      if (wr_ctrl1 && !wdata[C1_RXEN]) begin
        ovr_q <= 1'b0;
        frm_q <= 1'b0;
        per_q <= 1'b0;
      end
      if (rx_done_q && rx_accept) begin
        rxbuf_q   <= rx_word;
        rx_full_q <= 1'b1;
        if (rx_fe_q) frm_q <= 1'b1;
        if (rx_pe_q) per_q <= 1'b1;
        if (rx_full_q && !rd_rx) ovr_q <= 1'b1;
        else rx_irq_q <= 1'b1;
      end
    end
  end

  // register reads; data stand only in the cycle after the strobe
  logic [8:0] rx_out;
  assign rx_out = inv_data ? (~rxbuf_q & char_mask(char_len)) : rxbuf_q;
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 16'h0000;
    end else if (ce) begin
      rdata_q <= 16'h0000;
      if (rd) begin
        unique case (addr)
          ADDR_MODE:  rdata_q <= {8'h00, mode_q};
          ADDR_CTRL0: rdata_q <= {8'h00, ctrl0_q};
          ADDR_CTRL1: rdata_q <= {8'h00, ctrl1_q[7:4], rx_full_q, ctrl1_q[C1_RXEN],
                                  !tx_full_q, ctrl1_q[C1_TXEN]};
          ADDR_AUX:   rdata_q <= {8'h00, aux_q};
          ADDR_BRG:   rdata_q <= {8'h00, brg_q};
          ADDR_RXBUF: rdata_q <= {ovr_q | frm_q | per_q, per_q, frm_q, ovr_q,
                                  3'h0, rx_out};
          default:    rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  // pin drivers, registered; enables are low while driving
  logic sdo_q;
  logic sdo_oe_n_q;
  logic ck1_oe_n_q;
  logic ck2_oe_n_q;
  logic flow_oe_n_q;
  logic sep_oe_n_q;
  logic rts_q;
  logic tx_lvl;
  logic clk_drv;
  assign tx_lvl  = txd_q ^ inv_pin;
  assign clk_drv = sync_mode && !ext_clk;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sdo_q       <= 1'b1;
      sdo_oe_n_q  <= 1'b1;
      ck1_oe_n_q  <= 1'b1;
      ck2_oe_n_q  <= 1'b1;
      flow_oe_n_q <= 1'b1;
      sep_oe_n_q  <= 1'b1;
      rts_q       <= 1'b1;
    end else if (ce) begin
      sdo_q      <= ctrl0_q[C0_ODRAIN] ? 1'b0 : tx_lvl;
      sdo_oe_n_q <= !active || (ctrl0_q[C0_ODRAIN] && tx_lvl);
      ck1_oe_n_q <= !(clk_drv && (!multi_pin
                    || aux_q[AUX_CLKSEL +: 2] == CLKSEL_PIN1));
      ck2_oe_n_q <= !(clk_drv && multi_pin
                    && aux_q[AUX_CLKSEL +: 2] == CLKSEL_PIN2);
      rts_q       <= !(rx_en && !rx_full_q);
      flow_oe_n_q <= !(active && !flow_off && rts_sel && !sep_on);
      sep_oe_n_q  <= !(active && sep_on && rts_sel);
    end
  end

  assign serial_data_out              = sdo_q;
  assign serial_data_out_oe_n         = sdo_oe_n_q;
  assign transfer_clock_pin_out       = sclk_q;
  assign transfer_clock_pin_oe_n      = ck1_oe_n_q;
  assign second_clock_output_pin      = sclk_q;
  assign second_clock_output_pin_oe_n = ck2_oe_n_q;
  assign flow_pin_out                 = rts_q;
  assign flow_pin_oe_n                = flow_oe_n_q;
  assign flow_sep_rts_out             = rts_q;
  assign flow_sep_rts_oe_n            = sep_oe_n_q;
  assign tx_irq                       = tx_irq_q;
  assign rx_irq                       = rx_irq_q;
  assign rdata                        = rdata_q;

endmodule

// file: core/serial_io_uart_pkg.sv
// constants, register map and state types of the serial i/o channel
// assumes one 100 mhz clock and a plain address/strobe register port
package serial_io_uart_pkg;

  // register offsets (word index on the 3-bit port)
  localparam logic [2:0] ADDR_MODE  = 3'h0;
  localparam logic [2:0] ADDR_CTRL0 = 3'h1;
  localparam logic [2:0] ADDR_CTRL1 = 3'h2;
  localparam logic [2:0] ADDR_AUX   = 3'h3;
  localparam logic [2:0] ADDR_BRG   = 3'h4;
  localparam logic [2:0] ADDR_TXBUF = 3'h5;
  localparam logic [2:0] ADDR_RXBUF = 3'h6;

  // mode register fields
  localparam int MODE_EXT   = 3;
  localparam int MODE_STOP2 = 4;
  localparam int MODE_ODD   = 5;
  localparam int MODE_PAR   = 6;
  localparam int MODE_SLEEP = 7;
  localparam logic [2:0] MODE_SYNC = 3'h1;
  localparam logic [2:0] MODE_U7   = 3'h4;
  localparam logic [2:0] MODE_U8   = 3'h5;
  localparam logic [2:0] MODE_U9   = 3'h6;

  // control 0 fields
  localparam int C0_CLKSRC   = 0;
  localparam int C0_RTS      = 2;
  localparam int C0_FLOW_OFF = 4;
  localparam int C0_ODRAIN   = 5;
  localparam int C0_CPOL     = 6;
  localparam int C0_MSB      = 7;

  // control 1 fields
  localparam int C1_TXEN    = 0;
  localparam int C1_TXEMPTY = 1;
  localparam int C1_RXEN    = 2;
  localparam int C1_RXFULL  = 3;
  localparam int C1_TXCAUSE = 4;
  localparam int C1_CONTRX  = 5;
  localparam int C1_INVDATA = 6;
  localparam int C1_INVPIN  = 7;

  // aux fields
  localparam int AUX_CLKSEL = 4;
  localparam int AUX_SEP    = 6;
  localparam logic [1:0] CLKSEL_PIN1 = 2'h1;
  localparam logic [1:0] CLKSEL_PIN2 = 2'h2;

  // receive buffer word flags
  localparam int RX_OVR = 12;
  localparam int RX_FRM = 13;
  localparam int RX_PER = 14;
  localparam int RX_SUM = 15;

  // reset values
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [8:0] TXBUF_RST = 9'h000;

  // timing counts
  localparam logic [3:0] OS_LAST   = 4'hf;
  localparam logic [3:0] OS_HALF   = 4'h7;
  localparam logic [2:0] DIV8_LAST  = 3'h7;
  localparam logic [4:0] DIV32_LAST = 5'h1f;
  localparam logic [3:0] SYNC_LAST = 4'h7;
  localparam logic [3:0] LEN7 = 4'h7;
  localparam logic [3:0] LEN8 = 4'h8;
  localparam logic [3:0] LEN9 = 4'h9;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_SYNC} tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_type;

endpackage

// file: testbench/remote_uart.sv
// remote uart: sends and samples frames
// assumes an idle-high line and fixed bit time
`timescale 1ns/1ns
module remote_uart #(parameter int BIT_CYC = 16) (
  input  logic clk,
  input  logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;
  task automatic send(input logic [12:0] f, input int nb);
    for (int i = 0; i < nb; i++) begin
      line_out <= f[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    line_out <= 1'b1;
  endtask
  // samples mid-bit, so a slow edge still reads right
  task automatic recv(output logic [12:0] f, input int nb);
    f = 13'h1fff;
    while (line_in !== 1'b0) @(posedge clk);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      f[i] = line_in;
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask
endmodule

// file: testbench/serial_io_uart_checker.sv
// checker on the channel ports
// assumes the channel clk and its raw resetn
`timescale 1ns/1ns
module serial_io_uart_checker
  import serial_io_uart_pkg::*;
#(parameter int CHANNEL = 0) (
  input logic       clk,
  input logic       resetn,
  input logic [2:0] addr,
  input logic       wr,
  input logic       rd,
  input logic       serial_data_out,
  input logic       serial_data_out_oe_n,
  input logic       second_clock_output_pin_oe_n,
  input logic       flow_pin_out,
  input logic       flow_pin_oe_n,
  input logic       flow_sep_rts_oe_n,
  input logic       tx_irq,
  input logic       rx_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic tx_q;
  logic wr_q;
  logic rx_q;
  // flags track software actions and the request outputs, never the design's internals
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_q <= 1'b0;
      wr_q <= 1'b0;
      rx_q <= 1'b0;
    end else begin
      tx_q <= (wr && addr == ADDR_TXBUF) || (tx_q && !tx_irq);
      wr_q <= wr_q || (wr && addr == ADDR_TXBUF);
      rx_q <= rx_irq || (rx_q && !(rd && addr == ADDR_RXBUF));
    end
  end
  a_tx_pulse: assert property (tx_irq |=> !tx_irq)
    else $error("tx request too long");
  a_rx_pulse: assert property (rx_irq |=> !rx_irq)
    else $error("rx request too long");
  a_tx_cause: assert property (tx_irq |-> tx_q)
    else $error("tx request without data");
  a_rx_overrun: assert property (rx_irq |-> !rx_q)
    else $error("rx request on overrun");
  a_second_pin: assert property (CHANNEL != 1 |-> second_clock_output_pin_oe_n)
    else $error("second clock pin driven");
  a_flow_apart: assert property (!flow_pin_oe_n |-> flow_sep_rts_oe_n)
    else $error("rts on two pins");
  a_rts_full: assert property (rx_irq && !flow_pin_oe_n |-> ##[0:2] flow_pin_out)
    else $error("rts low with full buffer");
  a_idle_high: assert property (!wr_q && !serial_data_out_oe_n |-> serial_data_out)
    else $error("output low before transfer");
endmodule
bind serial_io_uart_channel serial_io_uart_checker #(.CHANNEL(CHANNEL)) i_checker (.*);

// file: testbench/test_serial_io_uart_channel.sv
// bench: channel 0 against a remote uart
// assumes divisor 0, so a bit lasts 16 clocks
`timescale 1ns/1ns
module test_serial_io_uart_channel;
  import serial_io_uart_pkg::*;
  logic clk = 0, resetn = 0, wr = 0, rd = 0, cts = 1, txd, oe_n, rxd, tx_irq, rx_irq;
  logic [2:0] addr = 0;
  logic [15:0] wdata = 0, rdata, w;
  logic [12:0] f, g;
  logic [8:0] d;
  logic [7:0] m;
  int n_errors = 0, checked = 0, n_tx = 0, n_rx = 0, nb;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    n_tx <= n_tx + (tx_irq === 1'b1);
    n_rx <= n_rx + (rx_irq === 1'b1);
  end
  serial_io_uart_channel #(.CHANNEL(0)) i_serial_io_uart_channel (.clk, .resetn,
    .ce(1'b1), .addr, .wdata, .wr, .rd, .rdata, .serial_data_in(rxd),
    .serial_data_out(txd), .serial_data_out_oe_n(oe_n), .transfer_clock_pin_in(1'b0),
    .transfer_clock_pin_out(), .transfer_clock_pin_oe_n(), .second_clock_output_pin(),
    .second_clock_output_pin_oe_n(), .flow_pin_in(cts), .flow_pin_out(),
    .flow_pin_oe_n(), .flow_sep_cts_in(1'b0), .flow_sep_rts_out(),
    .flow_sep_rts_oe_n(), .tx_irq, .rx_irq);
  remote_uart i_remote_uart (.clk, .line_in(oe_n | txd), .line_out(rxd));
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [12:0] frame(input logic [8:0] v, input logic [7:0] md,
                                        input logic msb, output int n);
    int len;
    len = md[2:0] == MODE_U7 ? 7 : md[2:0] == MODE_U9 ? 9 : 8;
    frame = 13'h1fff;
    frame[0] = 1'b0;
    for (int i = 0; i < len; i++) frame[i + 1] = v[msb ? len - 1 - i : i];
    if (md[MODE_PAR]) frame[len + 1] = ^(v & ~(9'h1ff << len)) ^ md[MODE_ODD];
    n = 2 + len + md[MODE_PAR] + md[MODE_STOP2];
  endfunction
  task automatic end_of_test;
    $display("errors %0d, comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'h1b29));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    wr_reg(ADDR_CTRL0, 16'h0000);
    wr_reg(ADDR_MODE, 16'h0005);
    wr_reg(ADDR_CTRL1, 16'h0004);
    wr_reg(ADDR_TXBUF, 16'h00a5);
    // held first by transmit disabled, then by cts still high
    for (int k = 0; k < 2; k++) begin
      repeat (40) @(posedge clk);
      chk(16'(oe_n | txd), 16'h0001);
      rd_reg(ADDR_CTRL1, w);
      chk(w, {13'h0, 1'b1, 1'b0, k == 1});
      wr_reg(ADDR_CTRL1, 16'h0005);
    end
    cts <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      m = k == 0 ? 8'h05 : k == 1 ? 8'h44 : 8'h76;
      d = k == 0 ? 9'h0a5 : 9'($urandom);
      if (k > 0) wr_reg(ADDR_MODE, {8'h00, m});
      if (k > 0) wr_reg(ADDR_CTRL0, {8'h00, k == 1, 7'h00});
      wr_reg(ADDR_CTRL1, 16'h0005);
      if (k > 0) wr_reg(ADDR_TXBUF, {7'h00, d});
      f = frame(d, m, k == 1, nb);
      i_remote_uart.recv(g, nb);
      chk({3'h0, g}, {3'h0, f});
    end
    chk(16'(n_tx), 16'h0003);
    wr_reg(ADDR_CTRL0, 16'h0004);
    for (int k = 0; k < 4; k++) begin
      m = k == 3 ? 8'h85 : 8'h45;
      wr_reg(ADDR_MODE, {8'h00, m});
      wr_reg(ADDR_CTRL1, 16'h0001);
      wr_reg(ADDR_CTRL1, 16'h0005);
      d = {1'b0, 8'($urandom)};
      g = frame(d & 9'h07f, m, 1'b0, nb);
      if (k > 1) i_remote_uart.send(g, nb);
      if (k == 3) d[7] = 1'b1;
      f = frame(d, m, 1'b0, nb);
      if (k == 1) f[9] = ~f[9];
      i_remote_uart.send(f, nb);
      repeat (16) @(posedge clk);
      rd_reg(ADDR_RXBUF, w);
      chk(w, {k == 1 || k == 2, k == 1, 1'b0, k == 2, 3'h0, d});
      chk(16'(n_rx), 16'(k + 1));
    end
    end_of_test;
  end
endmodule
